// ---- src/timer_readback_and_latch.sv ----
`timescale 1ns/1ps
`default_nettype none


module timer_readback_and_latch
  import timer_rb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [CNT_W-1:0] live_count0,
  input wire logic [CNT_W-1:0] live_count1,
  input wire logic [CNT_W-1:0] live_count2,
  input wire logic [NUM_CNT-1:0] out_level,
  input wire logic [NUM_CNT-1:0] null_count,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  output logic [1:0] rw_mode0,
  output logic [1:0] rw_mode1,
  output logic [1:0] rw_mode2,
  output logic [2:0] count_mode0,
  output logic [2:0] count_mode1,
  output logic [2:0] count_mode2,
  output logic [NUM_CNT-1:0] bcd_sel,
  output logic [NUM_CNT-1:0] count_held,
  output logic [NUM_CNT-1:0] status_held
);

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic [NUM_CNT-1:0] port_rd;
  logic [NUM_CNT-1:0] cap_count;
  logic [NUM_CNT-1:0] cap_status;
  logic [NUM_CNT-1:0] cfg_we;
  logic [CNT_W-1:0] live [NUM_CNT];
  logic [7:0] rd_byte [NUM_CNT];
  logic [1:0] rw_q [NUM_CNT];
  logic [2:0] mode_q [NUM_CNT];

  // a read in the same cycle wins; the write is dropped so that the
  // capture and release paths never fight over one snapshot
  assign ctrl_wr = io_wr & ~io_rd & (io_addr == PORT_CTRL);

  assign live[0] = live_count0;
  assign live[1] = live_count1;
  assign live[2] = live_count2;

  cmd_decode u_dec (
    .ctrl_wr(ctrl_wr),
    .cmd(io_wdata),
    .cap_count(cap_count),
    .cap_status(cap_status),
    .cfg_we(cfg_we)
  );

  // ----------------------------------------------------------------
  // per-counter configuration, capture and byte sequencing
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      logic [1:0] rw_r;
      logic [1:0] rw_nxt;
      logic [2:0] mode_r;
      logic [2:0] mode_nxt;
      logic bcd_r;
      logic bcd_nxt;
      logic hi_r;
      logic hi_nxt;
      logic rel_count;
      logic rel_status;
      logic last_byte;
      logic [7:0] status_byte;
      logic [7:0] byte_out;
      logic [CNT_W-1:0] src;
      logic held_c;
      logic held_s;
      logic [CNT_W-1:0] snap_c;
      logic [7:0] snap_s;

      // data ports sit at consecutive addresses from the base
      assign port_rd[i] = io_rd & (io_addr == PORT_CNT_BASE + 16'(i));

      // status byte as it stands now, frozen only by a capture
      assign status_byte = {out_level[i], null_count[i], rw_r, mode_r,
                            bcd_r};

      counter_snapshot u_snap (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cap_count(cap_count[i]),
        .cap_status(cap_status[i]),
        .rel_count(rel_count),
        .rel_status(rel_status),
        .live_count(live[i]),
        .status_in(status_byte),
        .count_held_r(held_c),
        .status_held_r(held_s),
        .snap_count_r(snap_c),
        .snap_status_r(snap_s)
      );

      // next configuration, read byte and release strobes
      always_comb begin
        rw_nxt = rw_r;
        mode_nxt = mode_r;
        bcd_nxt = bcd_r;
        hi_nxt = hi_r;
        rel_count = 1'b0;
        rel_status = 1'b0;
        last_byte = 1'b1;
        // a fresh configuration restarts the byte order at the low byte
        if (cfg_we[i]) begin
          rw_nxt = io_wdata[RW_HI:RW_LO];
          mode_nxt = io_wdata[MODE_HI:MODE_LO];
          bcd_nxt = io_wdata[BCD_BIT];
          hi_nxt = 1'b0;
        end
        src = held_c ? snap_c : live[i];
        unique case (rw_r)
          RW_LSB: byte_out = src[7:0];
          RW_MSB: byte_out = src[15:8];
          default: begin
            // latch code never reaches rw_r, so this is lsb-then-msb
            byte_out = hi_r ? src[15:8] : src[7:0];
            last_byte = hi_r;
          end
        endcase
        if (held_s) begin
          byte_out = snap_s;
        end
        if (port_rd[i]) begin
          if (held_s) begin
            rel_status = 1'b1;
          end else begin
            // own pointer per counter, so other ports may interleave
            if (rw_r == RW_BOTH) begin
              hi_nxt = ~hi_r;
            end
            if (held_c && last_byte) begin
              rel_count = 1'b1;
            end
          end
        end
      end

      // register stage
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          rw_r <= RST_RW;
          mode_r <= RST_MODE;
          bcd_r <= RST_BCD;
          hi_r <= 1'b0;
        end else begin
          rw_r <= rw_nxt;
          mode_r <= mode_nxt;
          bcd_r <= bcd_nxt;
          hi_r <= hi_nxt;
        end
      end

      assign rd_byte[i] = byte_out;
      assign rw_q[i] = rw_r;
      assign mode_q[i] = mode_r;
      assign bcd_sel[i] = bcd_r;
      assign count_held[i] = held_c;
      assign status_held[i] = held_s;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data return
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic valid_r;
  logic valid_nxt;

  // the command port is write-only, so it and unmapped ports read idle;
  // between reads the last answer is kept for a slow host
  always_comb begin
    rdata_nxt = rdata_r;
    valid_nxt = io_rd;
    if (io_rd) begin
      rdata_nxt = IDLE_RDATA;
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      if (port_rd[i]) begin
        rdata_nxt = rd_byte[i];
      end
    end
  end

  // one-cycle read answer, held until the next read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= IDLE_RDATA;
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign io_rdata = rdata_r;
  assign io_rdata_valid = valid_r;
  assign rw_mode0 = rw_q[0];
  assign rw_mode1 = rw_q[1];
  assign rw_mode2 = rw_q[2];
  assign count_mode0 = mode_q[0];
  assign count_mode1 = mode_q[1];
  assign count_mode2 = mode_q[2];

endmodule

`default_nettype wire

// ---- src/timer_rb_pkg.sv ----
package timer_rb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // i/o port map
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_CNT_BASE = 16'h0040; // counter n at base+n
  localparam logic [15:0] PORT_CTRL = 16'h0043;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int RB_NCOUNT = 5;
  localparam int RB_NSTATUS = 4;
  localparam int RB_SEL0 = 1;
  localparam int RW_HI = 5;
  localparam int RW_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int BCD_BIT = 0;

  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int ST_OUT = 7;
  localparam int ST_NULL = 6;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_RW = 2'h3;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic RST_BCD = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] IDLE_RDATA = 8'hFF;

endpackage

// ---- src/cmd_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// command word decoder
// ------------------------------------------------------------------
module cmd_decode
  import timer_rb_pkg::*;
(
  input wire logic ctrl_wr,
  input wire logic [7:0] cmd,
  output logic [NUM_CNT-1:0] cap_count,
  output logic [NUM_CNT-1:0] cap_status,
  output logic [NUM_CNT-1:0] cfg_we
);

  // sort a control write into read-back, count latch or configuration
  always_comb begin
    cap_count = '0;
    cap_status = '0;
    cfg_we = '0;
    if (ctrl_wr) begin
      if (cmd[SEL_HI:SEL_LO] == SEL_READBACK) begin
        // bit 0 is left to software and never looked at
        for (int i = 0; i < NUM_CNT; i++) begin
          cap_count[i] = cmd[RB_SEL0 + i] & ~cmd[RB_NCOUNT];
          cap_status[i] = cmd[RB_SEL0 + i] & ~cmd[RB_NSTATUS];
        end
      end else begin
        for (int i = 0; i < NUM_CNT; i++) begin
          if (cmd[SEL_HI:SEL_LO] == 2'(i)) begin
            if (cmd[RW_HI:RW_LO] == RW_LATCH) begin
              cap_count[i] = 1'b1;
            end else begin
              cfg_we[i] = 1'b1;
            end
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/counter_snapshot.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// per-counter capture of count and status
// ------------------------------------------------------------------
module counter_snapshot
  import timer_rb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cap_count,
  input wire logic cap_status,
  input wire logic rel_count,
  input wire logic rel_status,
  input wire logic [CNT_W-1:0] live_count,
  input wire logic [7:0] status_in,
  output logic count_held_r,
  output logic status_held_r,
  output logic [CNT_W-1:0] snap_count_r,
  output logic [7:0] snap_status_r
);

  logic count_held_nxt;
  logic status_held_nxt;
  logic [CNT_W-1:0] snap_count_nxt;
  logic [7:0] snap_status_nxt;

  // a held snapshot refuses a new capture until it is read out
  always_comb begin
    count_held_nxt = count_held_r;
    status_held_nxt = status_held_r;
    snap_count_nxt = snap_count_r;
    snap_status_nxt = snap_status_r;
    if (rel_count) begin
      count_held_nxt = 1'b0;
    end
    if (rel_status) begin
      status_held_nxt = 1'b0;
    end
    if (cap_count && !count_held_r) begin
      count_held_nxt = 1'b1;
      snap_count_nxt = live_count;
    end
    if (cap_status && !status_held_r) begin
      status_held_nxt = 1'b1;
      snap_status_nxt = status_in;
    end
  end

  // register stage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_held_r <= 1'b0;
      status_held_r <= 1'b0;
      snap_count_r <= RST_COUNT;
      snap_status_r <= RST_BYTE;
    end else begin
      count_held_r <= count_held_nxt;
      status_held_r <= status_held_nxt;
      snap_count_r <= snap_count_nxt;
      snap_status_r <= snap_status_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- tb/timer_rb_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module timer_rb_sva
  import timer_rb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  input wire logic [1:0] rw_mode0,
  input wire logic [2:0] count_mode0,
  input wire logic [NUM_CNT-1:0] count_held,
  input wire logic [NUM_CNT-1:0] status_held
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ----
  // commands: a read in the same cycle drops the write
  // ----
  sequence s_cmd;
    io_wr && !io_rd && io_addr == PORT_CTRL;
  endsequence
  sequence s_rb;
    s_cmd ##0 io_wdata[7:6] == SEL_READBACK;
  endsequence

  a_read_answer: assert property (io_rd |=> io_rdata_valid)
    else $error("read not answered");
  a_ctrl_idle: assert property (
    io_rd && io_addr == PORT_CTRL |=> io_rdata == IDLE_RDATA)
    else $error("control port read not idle");
  a_latch_holds: assert property (
    s_cmd ##0 io_wdata[5:4] == RW_LATCH && io_wdata[7:6] != SEL_READBACK
    |=> count_held[$past(io_wdata[7:6])])
    else $error("latch not held");
  a_rb_status0: assert property (
    s_rb ##0 !io_wdata[RB_NSTATUS] && io_wdata[RB_SEL0] |=> status_held[0])
    else $error("status not captured");
  a_rb_count2: assert property (
    s_rb ##0 !io_wdata[RB_NCOUNT] && io_wdata[3] |=> count_held[2])
    else $error("count not captured");
  a_rb_skip1: assert property (
    s_rb ##0 !io_wdata[2] && !count_held[1] && !status_held[1]
    |=> !count_held[1] && !status_held[1])
    else $error("unselected counter captured");
  a_status_first: assert property (
    status_held[0] && io_rd && io_addr == PORT_CNT_BASE
    |=> !status_held[0] && count_held[0] == $past(count_held[0]))
    else $error("status not read first");
  a_snap_kept: assert property (
    count_held[0] && !(io_rd && io_addr == PORT_CNT_BASE) |=> count_held[0])
    else $error("snapshot lost");
  a_cfg_load: assert property (
    s_cmd ##0 io_wdata[7:6] == 2'h0 && io_wdata[5:4] != RW_LATCH
    |=> rw_mode0 == $past(io_wdata[5:4])
    && count_mode0 == $past(io_wdata[3:1]))
    else $error("config not loaded");
endmodule

bind timer_readback_and_latch timer_rb_sva u_sva (.clk_sys, .arst_n,
  .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_valid,
  .rw_mode0, .count_mode0, .count_held, .status_held);

`default_nettype wire

// ---- tb/counter_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module counter_core_model
  import timer_rb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  output logic [CNT_W-1:0] live_count0,
  output logic [CNT_W-1:0] live_count1,
  output logic [CNT_W-1:0] live_count2,
  output logic [NUM_CNT-1:0] out_level,
  output logic [NUM_CNT-1:0] null_count
);
  // counts never stop, so a stale snapshot shows up at once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      live_count0 <= 16'hA5C3;
      live_count1 <= 16'h3C5A;
      live_count2 <= 16'hF00F;
    end else begin
      live_count0 <= live_count0 - 16'h0001;
      live_count1 <= live_count1 - 16'h0003;
      live_count2 <= live_count2 - 16'h0101;
    end
  end
  // pin and load flag toggle so both status levels occur
  assign out_level = {live_count2[8], live_count1[1], live_count0[2]};
  assign null_count = {live_count2[9], live_count1[2], live_count0[1]};
endmodule

`default_nettype wire

// ---- tb/timer_readback_and_latch_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module timer_readback_and_latch_tb_top
  import timer_rb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [CNT_W-1:0] lc [3];
  logic [NUM_CNT-1:0] out_level, null_count, bcd_sel, count_held, status_held;
  logic [7:0] io_rdata;
  logic io_rdata_valid;
  logic [1:0] rw_mode0, rw_mode1, rw_mode2;
  logic [2:0] count_mode0, count_mode1, count_mode2;
  logic [CNT_W-1:0] snap [3];
  logic [7:0] st_e [3];
  logic [1:0] rw_e [3] = '{2'h3, 2'h1, 2'h3};
  logic [2:0] md_e [3] = '{3'h2, 3'h1, 3'h3};
  logic [2:0] bcd_e = 3'b100;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  always #20 clk_sys = ~clk_sys;

  counter_core_model u_core (.clk_sys(clk_sys), .arst_n(arst_n),
    .live_count0(lc[0]), .live_count1(lc[1]), .live_count2(lc[2]),
    .out_level(out_level), .null_count(null_count));

  timer_readback_and_latch u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .live_count0(lc[0]), .live_count1(lc[1]), .live_count2(lc[2]),
    .out_level(out_level), .null_count(null_count), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .rw_mode0(rw_mode0),
    .rw_mode1(rw_mode1), .rw_mode2(rw_mode2), .count_mode0(count_mode0),
    .count_mode1(count_mode1), .count_mode2(count_mode2),
    .bcd_sel(bcd_sel), .count_held(count_held), .status_held(status_held));

  // ----
  // bus tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // m marks counters whose live value and status the command captures
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
      input logic [2:0] m);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    for (int c = 0; c < 3; c++) begin
      if (m[c]) begin
        snap[c] = lc[c];
        st_e[c] = {out_level[c], null_count[c], rw_e[c], md_e[c], bcd_e[c]};
      end
    end
    @(negedge clk_sys);
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    chk("valid", {15'h0, io_rdata_valid}, 16'h0001);
    chk("rdata", {8'h00, io_rdata}, {8'h00, e});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, the sequence needs fewer than a hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("held", {13'h0, count_held | status_held}, 16'h0000);
    rd(PORT_CTRL, IDLE_RDATA);
    rd(16'h0050, IDLE_RDATA);
    wr(PORT_CTRL, 8'h34, 3'h0);
    wr(PORT_CTRL, 8'h52, 3'h0);
    wr(PORT_CTRL, 8'hB7, 3'h0);
    chk("cfg2", {10'h0, rw_mode2, count_mode2, bcd_sel[2]}, 16'h0037);
    chk("cfg1", {10'h0, rw_mode1, count_mode1, bcd_sel[1]}, 16'h0012);
    $display("test reset and config done");
    // second latch must not refresh the first snapshot
    wr(PORT_CTRL, 8'h00, 3'h1);
    chk("held", {13'h0, count_held}, 16'h0001);
    repeat (3) @(negedge clk_sys);
    wr(PORT_CTRL, 8'h00, 3'h0);
    rd(PORT_CNT_BASE, snap[0][7:0]);
    wr(PORT_CTRL, 8'h52, 3'h0);
    wr(PORT_CTRL, 8'h80, 3'h4);
    rd(PORT_CNT_BASE, snap[0][15:8]);
    wr(PORT_CTRL, 8'h40, 3'h2);
    chk("held", {13'h0, count_held}, 16'h0006);
    rd(16'h0041, snap[1][7:0]);
    rd(16'h0042, snap[2][7:0]);
    rd(16'h0042, snap[2][15:8]);
    chk("held", {13'h0, count_held}, 16'h0000);
    $display("test latch done");
    wr(PORT_CTRL, 8'hCE, 3'h7);
    chk("held", {10'h0, count_held, status_held}, 16'h003F);
    for (int c = 0; c < 3; c++) begin
      rd(PORT_CNT_BASE + 16'(c), st_e[c]);
      rd(PORT_CNT_BASE + 16'(c), snap[c][7:0]);
      if (c != 1) begin
        rd(PORT_CNT_BASE + 16'(c), snap[c][15:8]);
      end
    end
    chk("held", {10'h0, count_held, status_held}, 16'h0000);
    chk("cfg0", {10'h0, rw_mode0, count_mode0, bcd_sel[0]}, 16'h0034);
    $display("test read-back all done");
    wr(PORT_CTRL, 8'hE4, 3'h2);
    chk("held", {10'h0, count_held, status_held}, 16'h0002);
    rd(16'h0041, st_e[1]);
    wr(PORT_CTRL, 8'hD8, 3'h4);
    chk("held", {10'h0, count_held, status_held}, 16'h0020);
    rd(16'h0042, snap[2][7:0]);
    rd(16'h0042, snap[2][15:8]);
    $display("test read-back select done");
    // msb-only access: one byte per snapshot, and it is the high one
    rw_e[1] = 2'h2;
    md_e[1] = 3'h2;
    wr(PORT_CTRL, 8'h64, 3'h0);
    chk("cfg1", {10'h0, rw_mode1, count_mode1, bcd_sel[1]}, 16'h0024);
    wr(PORT_CTRL, 8'h40, 3'h2);
    rd(16'h0041, snap[1][15:8]);
    chk("held", {13'h0, count_held}, 16'h0000);
    wr(PORT_CTRL, 8'hE4, 3'h2);
    rd(16'h0041, st_e[1]);
    $display("test msb-only done");
    wrap_up();
  end
endmodule

`default_nettype wire
